// file: pkg/rsc_pkg.sv
// shared types and constants of the reset strap configuration latch
// assumes the five-level strap sensing sits outside and hands over a code
`default_nettype none

package rsc_pkg;

	// ***************************************************************
	// sizes and timing
	// ***************************************************************
	localparam int RSC_NUM_PORTS = 4;
	localparam int RSC_LVL_W     = 3;
	localparam int RSC_CNT_W     = 3;
	// two-flop synchroniser depth on the strap pins
	localparam int RSC_SYNC_STAGES = 2;
	localparam logic [1:0] RSC_SETTLE_CYCLES = 2'(RSC_SYNC_STAGES);

	// ***************************************************************
	// five-level strap codes from the resistor sensing circuit
	// ***************************************************************
	localparam logic [RSC_LVL_W-1:0] RSC_LVL_200K_PD = 3'h0;
	localparam logic [RSC_LVL_W-1:0] RSC_LVL_200K_PU = 3'h1;
	localparam logic [RSC_LVL_W-1:0] RSC_LVL_10K_PD  = 3'h2;
	localparam logic [RSC_LVL_W-1:0] RSC_LVL_10K_PU  = 3'h3;
	localparam logic [RSC_LVL_W-1:0] RSC_LVL_10R_PD  = 3'h4;

	// ***************************************************************
	// types
	// ***************************************************************
	typedef enum logic [2:0] {
		RSC_MODE_CFG1,
		RSC_MODE_CFG2,
		RSC_MODE_CFG3,
		RSC_MODE_CFG4,
		RSC_MODE_RESERVED
	} rsc_mode_t;

	typedef enum logic [0:0] {
		RSC_PH_SETTLE,
		RSC_PH_HOLD
	} rsc_phase_t;

	typedef struct packed {
		logic [RSC_NUM_PORTS-1:0] portDplusDisableStrap;
		logic [RSC_NUM_PORTS-1:0] portDminusDisableStrap;
		logic [RSC_LVL_W-1:0]     fixedPortsCountStrap;
		logic [RSC_LVL_W-1:0]     chargingPortsCountStrap;
		logic [RSC_LVL_W-1:0]     modeStrap3;
		logic [RSC_LVL_W-1:0]     modeStrap2;
		logic [RSC_LVL_W-1:0]     modeStrap1;
	} rsc_strap_t;

	typedef struct packed {
		logic [RSC_NUM_PORTS-1:0] usb2PortDisable;
		logic [RSC_NUM_PORTS-1:0] ssPortDisable;
		logic [RSC_CNT_W-1:0]     fixedPortsCount;
		logic [RSC_NUM_PORTS-1:0] fixedPortsMask;
		logic [RSC_CNT_W-1:0]     chargingPortsCount;
		logic [RSC_NUM_PORTS-1:0] chargingPortsMask;
		rsc_mode_t                deviceMode;
	} rsc_cfg_t;

	// ***************************************************************
	// reset values
	// ***************************************************************
	localparam rsc_cfg_t RSC_CFG_RESET = '{
		usb2PortDisable:    '0,
		ssPortDisable:      '0,
		fixedPortsCount:    '0,
		fixedPortsMask:     '0,
		chargingPortsCount: '0,
		chargingPortsMask:  '0,
		deviceMode:         RSC_MODE_CFG1
	};

endpackage

`default_nettype wire

// file: logic/rsc_level_decode.sv
// five-level strap code to a port count and a mask starting at port 1
// assumes a code from the resistor sensing circuit; purely combinational
`default_nettype none

module rsc_level_decode
	import rsc_pkg::*;
#(
	parameter int NPORTS = RSC_NUM_PORTS
) (
	input  wire logic [RSC_LVL_W-1:0] level,
	output logic      [RSC_CNT_W-1:0] count,
	output logic      [NPORTS-1:0]    mask
);

	// ***************************************************************
	// level to count
	// ***************************************************************
	always_comb begin
		case (level)
			RSC_LVL_200K_PD: count = 3'h0;
			RSC_LVL_200K_PU: count = 3'h1;
			RSC_LVL_10K_PD:  count = 3'h2;
			RSC_LVL_10K_PU:  count = 3'h3;
			RSC_LVL_10R_PD:  count = 3'h4;
			// reserved codes fall back to the plain setting
			default:         count = 3'h0;
		endcase
	end

	// ***************************************************************
	// count to mask, lowest ports first
	// ***************************************************************
	always_comb begin
		for (int i = 0; i < NPORTS; i++) begin
			mask[i] = (RSC_CNT_W'(i) < count);
		end
	end

endmodule

`default_nettype wire

// file: logic/rsc_strap_latch.sv
// reset strap configuration latch for a four-port hub
// assumes strap pins are asynchronous to sys_clk and settle before
// resetn rises; resetn covers both power-on and external reset
`default_nettype none

module rsc_strap_latch
	import rsc_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire rsc_strap_t strapPins,
	output rsc_cfg_t  strapConfig,
	output logic      configValid
);

	// ***************************************************************
	// state
	// ***************************************************************
	typedef struct packed {
		rsc_phase_t phase;
		logic [1:0] settleCnt;
		rsc_strap_t syncMeta;
		rsc_strap_t syncStable;
		rsc_cfg_t   cfg;
	} rsc_state_t;

	localparam rsc_state_t RSC_STATE_RESET = '{
		phase:      RSC_PH_SETTLE,
		settleCnt:  '0,
		syncMeta:   '0,
		syncStable: '0,
		cfg:        RSC_CFG_RESET
	};

	rsc_state_t state;
	rsc_state_t next_state;

	// ***************************************************************
	// decoders on the synchronised five-level straps
	// ***************************************************************
	logic [RSC_CNT_W-1:0]     fixedCount;
	logic [RSC_NUM_PORTS-1:0] fixedMask;
	logic [RSC_CNT_W-1:0]     chargeCount;
	logic [RSC_NUM_PORTS-1:0] chargeMask;

	rsc_level_decode #(
		.NPORTS (RSC_NUM_PORTS)
	) fixedDecode (
		.level  (state.syncStable.fixedPortsCountStrap),
		.count  (fixedCount),
		.mask   (fixedMask)
	);

	rsc_level_decode #(
		.NPORTS (RSC_NUM_PORTS)
	) chargeDecode (
		.level  (state.syncStable.chargingPortsCountStrap),
		.count  (chargeCount),
		.mask   (chargeMask)
	);

	// ***************************************************************
	// mode decode: strap2 must be the weak pull-down, strap1 selects
	// ***************************************************************
	rsc_mode_t modeDecoded;

	always_comb begin
		modeDecoded = RSC_MODE_RESERVED;
		if (state.syncStable.modeStrap2 == RSC_LVL_200K_PD) begin
			case (state.syncStable.modeStrap1)
				RSC_LVL_200K_PD: modeDecoded = RSC_MODE_CFG1;
				RSC_LVL_200K_PU: modeDecoded = RSC_MODE_CFG2;
				RSC_LVL_10K_PD:  modeDecoded = RSC_MODE_CFG3;
				RSC_LVL_10K_PU:  modeDecoded = RSC_MODE_CFG4;
				default:         modeDecoded = RSC_MODE_RESERVED;
			endcase
		end
	end

	// ***************************************************************
	// port disable decode
	// ***************************************************************
	logic [RSC_NUM_PORTS-1:0] dplusOff;
	logic [RSC_NUM_PORTS-1:0] dminusOff;
	logic [RSC_NUM_PORTS-1:0] portOff;

	// a 1 on a data-line strap marks that line disabled
	assign dplusOff  = state.syncStable.portDplusDisableStrap;
	assign dminusOff = state.syncStable.portDminusDisableStrap;
	// one line alone does not take the port down
	assign portOff   = dplusOff & dminusOff;

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb begin
		next_state = state;
		// strap3 is not used, so only the other fields are synchronised
		next_state.syncMeta = strapPins;
		next_state.syncMeta.modeStrap3 = '0;
		next_state.syncStable = state.syncMeta;
		case (state.phase)
			RSC_PH_SETTLE: begin
				// wait until the pin levels at release reach syncStable
				if (state.settleCnt == RSC_SETTLE_CYCLES) begin
					next_state.phase = RSC_PH_HOLD;
					next_state.cfg.usb2PortDisable = portOff;
					next_state.cfg.ssPortDisable = portOff;
					next_state.cfg.fixedPortsCount = fixedCount;
					next_state.cfg.fixedPortsMask = fixedMask;
					next_state.cfg.chargingPortsCount = chargeCount;
					next_state.cfg.chargingPortsMask = chargeMask;
					next_state.cfg.deviceMode = modeDecoded;
				end else begin
					next_state.settleCnt = state.settleCnt + 2'h1;
				end
			end
			RSC_PH_HOLD: begin
				// settings frozen until the next reset
				next_state.cfg = state.cfg;
			end
			default: begin
				next_state.phase = RSC_PH_SETTLE;
			end
		endcase
	end

	// ***************************************************************
	// registers
	// ***************************************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			// reset held by board until straps settle
			state <= RSC_STATE_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign strapConfig = state.cfg;
	assign configValid = (state.phase == RSC_PH_HOLD);

endmodule

`default_nettype wire

// file: dv/rsc_strap_latch_asserts.sv
// checker for rsc_strap_latch, bound to its ports
// assumes one clock domain and the async active-low reset
`default_nettype none
module rsc_strap_latch_asserts
	import rsc_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       resetn,
	input wire rsc_strap_t strapPins,
	input wire rsc_cfg_t   strapConfig,
	input wire logic       configValid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] edges;
	rsc_strap_t p1;
	rsc_strap_t p2;
	// edges since release, saturating
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			edges <= '0;
		else if (edges != 3'h7)
			edges <= edges + 3'h1;
	end
	always_ff @(posedge sys_clk) begin
		p1 <= strapPins;
		p2 <= p1;
	end
	function automatic logic [2:0] lc(input logic [2:0] l);
		return (l <= 3'h4) ? l : 3'h0;
	endfunction
	function automatic logic [3:0] th(input logic [2:0] c);
		return 4'((5'h1 << c) - 5'h1);
	endfunction
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	property p_validTime; configValid == (edges >= 3'h3); endproperty
	a_validTime: assert property (p_validTime) else $error("valid late");
	property p_hold;
		configValid |=> configValid && $stable(strapConfig);
	endproperty
	a_hold: assert property (p_hold) else $error("config moved");
	property p_ss;
		strapConfig.ssPortDisable == strapConfig.usb2PortDisable;
	endproperty
	a_ss: assert property (p_ss) else $error("ss path differs");
	property p_pre; !configValid |-> strapConfig == RSC_CFG_RESET; endproperty
	a_pre: assert property (p_pre) else $error("early config");
	property p_dis; $rose(configValid) |-> strapConfig.usb2PortDisable ==
		(p2.portDplusDisableStrap & p2.portDminusDisableStrap); endproperty
	a_dis: assert property (p_dis) else $error("bad disable");
	property p_cnt; $rose(configValid) |->
		strapConfig.fixedPortsCount == lc(p2.fixedPortsCountStrap) &&
		strapConfig.chargingPortsCount == lc(p2.chargingPortsCountStrap);
	endproperty
	a_cnt: assert property (p_cnt) else $error("bad count");
	property p_mask; configValid |-> strapConfig.fixedPortsMask ==
		th(strapConfig.fixedPortsCount) && strapConfig.chargingPortsMask ==
		th(strapConfig.chargingPortsCount); endproperty
	a_mask: assert property (p_mask) else $error("bad mask");
	property p_mode; $rose(configValid) |-> strapConfig.deviceMode ==
		((p2.modeStrap2 == 3'h0 && p2.modeStrap1 < 3'h4) ?
		rsc_mode_t'(p2.modeStrap1) : RSC_MODE_RESERVED); endproperty
	a_mode: assert property (p_mode) else $error("bad mode");
endmodule
bind rsc_strap_latch rsc_strap_latch_asserts rsc_strap_latch_asserts_inst (
	.sys_clk(sys_clk), .resetn(resetn), .strapPins(strapPins),
	.strapConfig(strapConfig), .configValid(configValid));
`default_nettype wire

// file: dv/rsc_board_model.sv
// board model: strap resistors and the reset source
// assumes the bench changes plan and resetReq at the falling edge
`default_nettype none
module rsc_board_model
	import rsc_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       resetReq,
	input  wire rsc_strap_t plan,
	output rsc_strap_t      strapPins,
	output logic            resetn
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		strapPins = '0;
		resetn = 1'b0;
	end
	always @(negedge sys_clk) begin
		strapPins <= plan;
		// release only once pins sit at their planned level
		resetn <= !resetReq && (resetn || strapPins === plan);
	end
endmodule
`default_nettype wire

// file: dv/tb_rsc_strap_latch.sv
// self-checking bench for rsc_strap_latch
// assumes rsc_pkg, the checker and the board model are compiled first
`default_nettype none
module tb_rsc_strap_latch
	import rsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk = 1'b0;
	logic       resetReq = 1'b1;
	logic       resetn;
	logic       configValid;
	rsc_strap_t plan = '0;
	rsc_strap_t strapPins;
	rsc_cfg_t   cfg;
	int         n_errors = 0;
	int         n_checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	rsc_board_model rsc_board_model_inst (.sys_clk(sys_clk),
		.resetReq(resetReq), .plan(plan), .strapPins(strapPins),
		.resetn(resetn));
	rsc_strap_latch rsc_strap_latch_inst (.sys_clk(sys_clk),
		.resetn(resetn), .strapPins(strapPins), .strapConfig(cfg),
		.configValid(configValid));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic capture(input rsc_strap_t s);
		@(negedge sys_clk);
		resetReq <= 1'b1;
		plan <= s;
		repeat (17) @(negedge sys_clk);
		chk(configValid, 1'b0);
		chk(cfg, RSC_CFG_RESET);
		resetReq <= 1'b0;
		@(posedge resetn);
		repeat (2) @(negedge sys_clk);
		chk(configValid, 1'b0);
		@(negedge sys_clk);
		chk(configValid, 1'b1);
	endtask
	task automatic test_ports();
		rsc_strap_t s;
		logic [3:0] e;
		for (int i = 0; i < 16; i += 5) begin
			s = '0;
			s.portDplusDisableStrap = 4'(i);
			s.portDminusDisableStrap = 4'(i) ^ 4'h3;
			e = 4'(i) & (4'(i) ^ 4'h3);
			capture(s);
			chk(cfg.usb2PortDisable, e);
			chk(cfg.ssPortDisable, e);
		end
		$display("ports done");
	endtask
	task automatic test_levels();
		rsc_strap_t s;
		int n;
		int c;
		for (int l = 0; l < 6; l++) begin
			n = (l == 5) ? 0 : l;
			c = (l == 5) ? 0 : 4 - l;
			s = '0;
			s.fixedPortsCountStrap = (l == 5) ? 3'h7 : 3'(n);
			s.chargingPortsCountStrap = (l == 5) ? 3'h7 : 3'(c);
			capture(s);
			chk(cfg.fixedPortsCount, n);
			chk(cfg.fixedPortsMask, (1 << n) - 1);
			chk(cfg.chargingPortsCount, c);
			chk(cfg.chargingPortsMask, (1 << c) - 1);
		end
		$display("levels done");
	endtask
	task automatic test_modes();
		rsc_strap_t s;
		rsc_mode_t  e;
		for (int m = 0; m < 6; m++) begin
			s = '0;
			s.modeStrap3 = 3'h4;
			s.modeStrap1 = (m == 5) ? 3'h0 : 3'(m);
			s.modeStrap2 = (m == 5) ? 3'h1 : 3'h0;
			capture(s);
			e = (m < 4) ? rsc_mode_t'(m) : RSC_MODE_RESERVED;
			chk(cfg.deviceMode, e);
		end
		$display("modes done");
	endtask
	task automatic test_hold();
		rsc_strap_t s;
		s = '0;
		s.portDplusDisableStrap = 4'hB;
		s.portDminusDisableStrap = 4'hB;
		s.fixedPortsCountStrap = 3'h2;
		capture(s);
		plan <= ~s;
		repeat (10) @(negedge sys_clk);
		chk(cfg.usb2PortDisable, 4'hB);
		chk(cfg.ssPortDisable, 4'hB);
		chk(cfg.fixedPortsCount, 3'h2);
		chk(configValid, 1'b1);
		$display("hold done");
	endtask
	initial begin
		test_ports();
		test_levels();
		test_modes();
		test_hold();
		finish_test();
	end
	initial begin
		#20us;
		n_errors++;
		finish_test();
	end
endmodule
`default_nettype wire
